// [logic/ehrs_consts.svh]
// Constants for the run/stop, controller reset and status register block
`ifndef EHRS_CONSTS_SVH
`define EHRS_CONSTS_SVH

// ==========================================
// Register map (byte addresses in operational space)
`define EHRS_ADDR_W 8
`define EHRS_OFS_CMD 8'h20
`define EHRS_OFS_STS 8'h24

// ==========================================
// Command field positions
`define EHRS_CMD_RS 0
`define EHRS_CMD_HCRST 1
`define EHRS_CMD_PSE 4
`define EHRS_CMD_ASE 5

// ==========================================
// Status field positions
`define EHRS_STS_EVT_LSB 0
`define EHRS_STS_HSE 4
`define EHRS_STS_HCH 12
`define EHRS_STS_ASYNC_EMPTY_DETECT 13
`define EHRS_STS_PSS 14
`define EHRS_STS_ASS 15
// Pending bits that software may clear; bit 5 is read-only
`define EHRS_STS_W1C_MASK 6'h1F

// ==========================================
// Reset values
`define EHRS_RS_RST 1'b0
`define EHRS_EN_RST 1'b0
`define EHRS_SCHED_RST 1'b0
`define EHRS_HCH_RST 1'b1
`define EHRS_EVT_RST 6'h00
`define EHRS_WORD_RST 32'h0000_0000

// ==========================================
// Timing
`define EHRS_CLK_PERIOD_NS 8
`define EHRS_SRST_TIME_NS 64
`define EHRS_SRST_CYCLES ((`EHRS_SRST_TIME_NS + `EHRS_CLK_PERIOD_NS - 1) / `EHRS_CLK_PERIOD_NS)

`endif

// [logic/ehrs_pkg.sv]
// Types shared by the run/stop, reset and status block
package ehrs_pkg;

    // ==========================================
    // Event pulses from the schedule engine, in status bit order
    typedef struct packed {
        logic async_advance_irq;   // Async advance
        logic host_sys_error;   // Host system error
        logic frame_rollover;   // Frame list rollover
        logic port_change;   // Port change
        logic err;   // Transfer error
        logic done;  // Transfer done
    } ehrs_evt_t;

    // ==========================================
    // Schedule state reported to the engine
    typedef struct packed {
        logic async_sched_status;
        logic periodic_sched_status;
        logic async_empty_detect;
        logic halted_flag;
    } ehrs_state_t;

    // ==========================================
    // Soft reset sequencer states
    typedef enum logic [2:0] {
        EHRS_SR_IDLE = 3'b001,
        EHRS_SR_HOLD = 3'b010,
        EHRS_SR_DONE = 3'b100
    } ehrs_srst_state_t;

endpackage

// [logic/ehrs_srst_seq.sv]
// Soft reset sequencer: holds the core in reset, then reports completion
`timescale 1ns/1ps
`include "ehrs_consts.svh"
module ehrs_srst_seq #(
    parameter int HOLD_CYCLES = `EHRS_SRST_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Control
    input wire logic start,
    // Status
    output logic core_reset,
    output logic done,
    output logic busy
);
    localparam int CW = $clog2(HOLD_CYCLES + 1);

    ehrs_pkg::ehrs_srst_state_t state_q;  // Current state
    ehrs_pkg::ehrs_srst_state_t state_d;  // Next state
    logic [CW-1:0] cnt_q;  // Cycles spent in hold
    logic [CW-1:0] cnt_d;

    // ==========================================
    // Next state
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        case (state_q)
            ehrs_pkg::EHRS_SR_IDLE: begin
                cnt_d = '0;
                if (start) begin
                    state_d = ehrs_pkg::EHRS_SR_HOLD;
                end
            end
            ehrs_pkg::EHRS_SR_HOLD: begin
                // Start requests in this window are ignored on purpose
                if (cnt_q == CW'(HOLD_CYCLES - 1)) begin
                    state_d = ehrs_pkg::EHRS_SR_DONE;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            ehrs_pkg::EHRS_SR_DONE: begin
                state_d = ehrs_pkg::EHRS_SR_IDLE;
            end
            default: begin
                state_d = ehrs_pkg::EHRS_SR_IDLE;
            end
        endcase
    end

    // ==========================================
    // State registers
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= ehrs_pkg::EHRS_SR_IDLE;
            cnt_q <= '0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    // Outputs decode straight from the state flops
    assign core_reset = (state_q == ehrs_pkg::EHRS_SR_HOLD);
    assign done = (state_q == ehrs_pkg::EHRS_SR_DONE);
    assign busy = (state_q != ehrs_pkg::EHRS_SR_IDLE);

    // ==========================================
    // Checks (hold count written for the default of eight cycles)
    sequence s_hold_then_done;
        core_reset [*8] ##1 (done && !core_reset);
    endsequence

    a_hold_length: assert property (
        @(posedge clock) disable iff (sys_rst)
        (start && !busy) |=> s_hold_then_done)
        else $error("soft reset hold length wrong");

    a_done_single: assert property (
        @(posedge clock) disable iff (sys_rst)
        done |=> !done && !core_reset)
        else $error("completion not a single pulse");

endmodule

// [logic/ehrs_run_reset_status.sv]
// Run/stop, controller soft reset and status register block
`timescale 1ns/1ps
`include "ehrs_consts.svh"
module ehrs_run_reset_status #(
    parameter int SRST_CYCLES = `EHRS_SRST_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Operational register port
    input wire logic reg_req,
    input wire logic reg_we,
    input wire logic [`EHRS_ADDR_W-1:0] reg_addr,
    input wire logic [3:0] reg_be,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic reg_ack,
    // Schedule engine
    input wire logic pipe_idle,
    input wire logic sched_boundary,
    input wire logic async_empty_set,
    input wire logic async_empty_clr,
    input wire ehrs_pkg::ehrs_evt_t evt,
    output logic sched_run,
    output logic async_run,
    output logic periodic_run,
    output ehrs_pkg::ehrs_state_t sched_state,
    // Core reset fan-out
    output logic core_reset,
    output logic txn_abort,
    output logic port_own_release,
    output logic bus_reset_block
);

    // ==========================================
    // Declarations
    logic run_stop_q;  // Run when set
    logic run_stop_d;
    logic pse_q;  // Periodic enable
    logic pse_d;
    logic ase_q;  // Async enable
    logic ase_d;
    logic hcr_q;  // Soft reset request bit
    logic hcr_d;
    logic halted_q;  // Halted flag
    logic halted_d;
    logic pss_q;  // Periodic schedule status
    logic pss_d;
    logic ass_q;  // Async schedule status
    logic ass_d;
    logic async_empty_detect_q;  // Async empty detect
    logic async_empty_detect_d;
    logic [5:0] evt_q;  // Pending event bits
    logic [5:0] evt_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic ack_q;
    logic abort_q;
    logic [5:0] evt_v;  // Event pulses as a vector
    logic [5:0] w1c;  // Bits software clears this cycle
    logic wr_cmd;
    logic wr_sts;
    logic srst_start;
    logic srst_done;
    logic srst_busy;
    logic clr_ops;  // Operational registers back to reset values

    // Address match, used for both reads and writes
    function automatic logic hit(input logic [`EHRS_ADDR_W-1:0] a,
                                 input logic [`EHRS_ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction

    // ==========================================
    // Access decode
    assign evt_v = evt;
    // Writes are dropped while a soft reset runs so nothing half-resets
    assign wr_cmd = reg_req && reg_we && reg_be[0] && !hcr_q && hit(reg_addr, `EHRS_OFS_CMD);
    assign wr_sts = reg_req && reg_we && reg_be[0] && !hcr_q && hit(reg_addr, `EHRS_OFS_STS);
    assign w1c = wr_sts ? (reg_wdata[5:0] & `EHRS_STS_W1C_MASK) : 6'h00;
    assign srst_start = wr_cmd && reg_wdata[`EHRS_CMD_HCRST];
    assign clr_ops = srst_start || core_reset;

    // ==========================================
    // Soft reset sequencer
    ehrs_srst_seq #(
        .HOLD_CYCLES(SRST_CYCLES)
    ) u_srst (
        .clock(clock),
        .sys_rst(sys_rst),
        .start(srst_start),
        .core_reset(core_reset),
        .done(srst_done),
        .busy(srst_busy)
    );

    // ==========================================
    // Command bits next values
    always_comb begin
        run_stop_d = run_stop_q;
        pse_d = pse_q;
        ase_d = ase_q;
        hcr_d = hcr_q;
        if (clr_ops) begin
            // Run/stop and both schedule enables return to their initial state; the reset bit is set below
            run_stop_d = `EHRS_RS_RST;
            pse_d = `EHRS_EN_RST;
            ase_d = `EHRS_EN_RST;
        end else begin
            if (wr_cmd) begin
                run_stop_d = reg_wdata[`EHRS_CMD_RS];
                pse_d = reg_wdata[`EHRS_CMD_PSE];
                ase_d = reg_wdata[`EHRS_CMD_ASE];
            end
            // A host bus error beats a software start in the same cycle
            if (evt.host_sys_error) begin
                run_stop_d = 1'b0;
            end
        end
        // Writing zero cannot end the reset early; only completion clears it
        if (srst_done) begin
            hcr_d = 1'b0;
        end else if (srst_start) begin
            hcr_d = 1'b1;
        end
    end

    // ==========================================
    // Status bits next values
    always_comb begin
        halted_d = halted_q;
        pss_d = pss_q;
        ass_d = ass_q;
        async_empty_detect_d = async_empty_detect_q;
        evt_d = evt_q;
        if (clr_ops) begin
            halted_d = `EHRS_HCH_RST;
            pss_d = `EHRS_SCHED_RST;
            ass_d = `EHRS_SCHED_RST;
            async_empty_detect_d = `EHRS_SCHED_RST;
            evt_d = `EHRS_EVT_RST;
        end else begin
            // Halted only once the pipeline drained after run/stop fell
            if (run_stop_d) begin
                halted_d = 1'b0;
            end else if (pipe_idle) begin
                halted_d = 1'b1;
            end
            // Enables take effect at a schedule boundary, or at once when halted
            if (sched_boundary || halted_q) begin
                pss_d = pse_q;
                ass_d = ase_q;
            end
            // Set wins over clear and over an off async schedule, which otherwise drops the empty flag
            if (async_empty_set) begin
                async_empty_detect_d = 1'b1;
            end else if (async_empty_clr || !ass_q) begin
                async_empty_detect_d = 1'b0;
            end
            evt_d = evt_v | (evt_q & ~w1c);
        end
    end

    // ==========================================
    // Read data; frame list size and reserved bits read as zero
    always_comb begin
        rdata_d = `EHRS_WORD_RST;
        if (reg_req && !reg_we && hit(reg_addr, `EHRS_OFS_CMD)) begin
            rdata_d[`EHRS_CMD_RS] = run_stop_q;
            rdata_d[`EHRS_CMD_HCRST] = hcr_q;
            rdata_d[`EHRS_CMD_PSE] = pse_q;
            rdata_d[`EHRS_CMD_ASE] = ase_q;
        end else if (reg_req && !reg_we && hit(reg_addr, `EHRS_OFS_STS)) begin
            rdata_d[5:0] = evt_q;
            rdata_d[`EHRS_STS_HCH] = halted_q;
            rdata_d[`EHRS_STS_ASYNC_EMPTY_DETECT] = async_empty_detect_q;
            rdata_d[`EHRS_STS_PSS] = pss_q;
            rdata_d[`EHRS_STS_ASS] = ass_q;
        end
    end

    // ==========================================
    // Registers
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            run_stop_q <= `EHRS_RS_RST;
            pse_q <= `EHRS_EN_RST;
            ase_q <= `EHRS_EN_RST;
            hcr_q <= 1'b0;
            halted_q <= `EHRS_HCH_RST;
            pss_q <= `EHRS_SCHED_RST;
            ass_q <= `EHRS_SCHED_RST;
            async_empty_detect_q <= `EHRS_SCHED_RST;
            evt_q <= `EHRS_EVT_RST;
            rdata_q <= `EHRS_WORD_RST;
            ack_q <= 1'b0;
            abort_q <= 1'b0;
        end else begin
            run_stop_q <= run_stop_d;
            pse_q <= pse_d;
            ase_q <= ase_d;
            hcr_q <= hcr_d;
            halted_q <= halted_d;
            pss_q <= pss_d;
            ass_q <= ass_d;
            async_empty_detect_q <= async_empty_detect_d;
            evt_q <= evt_d;
            rdata_q <= rdata_d;
            ack_q <= reg_req;
            abort_q <= srst_start;
        end
    end

    // ==========================================
    // Outputs
    assign reg_rdata = rdata_q;
    assign reg_ack = ack_q;
    // Schedule keeps running while run/stop is set and no reset is active
    assign sched_run = run_stop_q && !core_reset;
    assign async_run = ass_q;
    assign periodic_run = pss_q;
    assign sched_state = {ass_q, pss_q, async_empty_detect_q, halted_q};
    // Abort from the cycle after the request; ports go back to companions and must not send bus reset
    assign txn_abort = abort_q || core_reset;
    assign port_own_release = core_reset;
    assign bus_reset_block = core_reset;

    // ==========================================
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    // Completion shows one cycle after the hold, so the latency tracks the parameter
    localparam int SRST_LAT = SRST_CYCLES + 1;

    sequence s_reset_finish;
        srst_done ##1 (!hcr_q && !run_stop_q && halted_q);
    endsequence

    a_run_not_halted: assert property (
        run_stop_q |-> !halted_q)
        else $error("halted while running");
    a_stop_to_halt: assert property (
        (!run_stop_q && !clr_ops && !wr_cmd && pipe_idle) |=> halted_q)
        else $error("halted flag not set after stop");
    a_wait_drain: assert property (
        (!run_stop_q && !halted_q && !pipe_idle && !clr_ops) |=> !halted_q)
        else $error("halted before pipeline drained");
    a_hse_stop: assert property (
        (evt.host_sys_error && !clr_ops) |=> (!run_stop_q && evt_q[`EHRS_STS_HSE]))
        else $error("host error did not stop schedule");
    a_w1c_clear: assert property (
        (wr_sts && reg_wdata[0] && !evt.done) |=> !evt_q[0])
        else $error("pending bit not cleared by one");
    a_w1c_keep: assert property (
        (evt_q[1] && !clr_ops && !(wr_sts && reg_wdata[1])) |=> evt_q[1])
        else $error("pending bit lost without a one write");
    a_set_wins: assert property (
        (evt.done && !clr_ops) |=> evt_q[0])
        else $error("event lost against clear");
    a_hcr_sticky: assert property (
        (hcr_q && !srst_done) |=> hcr_q)
        else $error("reset bit cleared early");
    a_reset_finish: assert property (
        srst_start |-> ##SRST_LAT s_reset_finish)
        else $error("soft reset did not end stopped and halted");
    a_ports_release: assert property (
        core_reset |-> (port_own_release && bus_reset_block && txn_abort && !sched_run))
        else $error("ports not released during reset");
    a_sched_follow: assert property (
        (sched_boundary && !clr_ops) |=> (ass_q == $past(ase_q) && pss_q == $past(pse_q)))
        else $error("schedule status did not follow enable");
    a_async_empty_detect_off: assert property (
        (!ass_q && !async_empty_set) |=> !async_empty_detect_q)
        else $error("empty flag set with async schedule off");

    // ==========================================
    // Checks on the reset fan-out and refused writes
    // Abort and port hand-back must start the cycle after the request
    a_abort_start: assert property (
        srst_start |=> (txn_abort && core_reset && port_own_release))
        else $error("abort not raised after reset request");
    // Every pending and schedule bit is back at its initial value
    a_reset_clears: assert property (
        core_reset |=> (evt_q == `EHRS_EVT_RST && halted_q && !pss_q && !ass_q && !async_empty_detect_q))
        else $error("status not cleared by soft reset");
    // The sequencer is busy only while the reset bit still reads one
    a_busy_flag: assert property (
        srst_busy |-> hcr_q)
        else $error("sequencer busy with reset bit clear");
    // While the reset bit reads one a command write has no effect
    a_refuse_write: assert property (
        (hcr_q && !clr_ops && !evt.host_sys_error) |=> (run_stop_q == $past(run_stop_q)))
        else $error("command write taken during soft reset");
    // A run write lowers the halted flag on the same edge that sets run/stop
    a_run_unhalt: assert property (
        (wr_cmd && reg_wdata[`EHRS_CMD_RS] && !clr_ops && !evt.host_sys_error)
        |=> (run_stop_q && !halted_q))
        else $error("run write did not clear halted");
    // Every request, refused or not, gets its answer one cycle later
    a_ack_follow: assert property (
        reg_req |=> reg_ack)
        else $error("register access not acknowledged");

endmodule

// [bench/ehrs_run_reset_status_tb.sv]
// Self-checking testbench for the run/stop, soft reset and status register block
`timescale 1ns/1ps
`include "ehrs_consts.svh"
module ehrs_run_reset_status_tb;
    // ==========================================
    // Stimulus and observed signals
    logic clock;
    logic sys_rst;
    logic reg_req, reg_we;
    logic [`EHRS_ADDR_W-1:0] reg_addr;
    logic [3:0] reg_be;
    logic [31:0] reg_wdata, reg_rdata;
    logic reg_ack;
    logic pipe_idle, sched_boundary, async_empty_set, async_empty_clr;
    ehrs_pkg::ehrs_evt_t evt;
    logic sched_run, async_run, periodic_run;
    ehrs_pkg::ehrs_state_t sched_state;
    logic core_reset, txn_abort, port_own_release, bus_reset_block;
    int mismatches, num_checks, cycles;
    logic [31:0] rd; // Last read data
    // Status value of an idle, freshly reset controller: only halted set
    localparam logic [31:0] STS_IDLE = 32'h0000_1000;

    // ==========================================
    // Design under test, default reset hold length
    ehrs_run_reset_status dut_u (
        .clock(clock), .sys_rst(sys_rst),
        .reg_req(reg_req), .reg_we(reg_we), .reg_addr(reg_addr), .reg_be(reg_be),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
        .pipe_idle(pipe_idle), .sched_boundary(sched_boundary),
        .async_empty_set(async_empty_set), .async_empty_clr(async_empty_clr), .evt(evt),
        .sched_run(sched_run), .async_run(async_run), .periodic_run(periodic_run),
        .sched_state(sched_state), .core_reset(core_reset), .txn_abort(txn_abort),
        .port_own_release(port_own_release), .bus_reset_block(bus_reset_block)
    );

    // ==========================================
    // Clock at 125 MHz
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // ==========================================
    // Hang guard: the whole run needs well under a thousand cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            wrap_up();
        end
    end

    // ==========================================
    // Shared helpers
    task automatic wrap_up();
        if (mismatches == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Compare one value; four-state compare so unknowns never match
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One register access; the answer comes exactly one cycle after the request edge
    task automatic access(input logic we, input logic [7:0] addr, input logic [31:0] wd,
                          input logic [3:0] be = 4'hF);
        @(posedge clock);
        reg_req <= 1'b1;
        reg_we <= we;
        reg_addr <= addr;
        reg_wdata <= wd;
        reg_be <= be;
        @(posedge clock);
        reg_req <= 1'b0;
        #1;
        rd = reg_rdata;
        check("reg_ack", {31'h0, reg_ack}, 32'h0000_0001);
    endtask

    // Read a register and compare it with the expected word
    task automatic rd_chk(input string what, input logic [7:0] addr, input logic [31:0] exp);
        access(1'b0, addr, 32'h0000_0000);
        check(what, rd, exp);
    endtask

    // Let n edges pass, then sample settled values
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // One-cycle event pulse from the schedule engine
    task automatic pulse_evt(input ehrs_pkg::ehrs_evt_t v);
        @(posedge clock);
        evt <= v;
        @(posedge clock);
        evt <= 6'h00;
    endtask

    // ==========================================
    // Scenarios
    task automatic t_reset_values();
        check("halted_after_reset", {28'h0, sched_state}, 32'h0000_0001);
        check("core_reset_idle", {31'h0, core_reset}, 32'h0000_0000);
        rd_chk("cmd_reset", `EHRS_OFS_CMD, 32'h0000_0000);
        rd_chk("sts_reset", `EHRS_OFS_STS, STS_IDLE);
        rd_chk("unmapped_read", 8'h40, 32'h0000_0000);
    endtask

    // Run, then stop while the pipeline is still busy
    task automatic t_run_stop();
        @(posedge clock);
        pipe_idle <= 1'b0;
        // Software confirms the halted state before it starts the schedule
        rd_chk("sts_before_run", `EHRS_OFS_STS, STS_IDLE);
        access(1'b1, `EHRS_OFS_CMD, 32'h0000_0001);
        check("sched_run_on", {31'h0, sched_run}, 32'h0000_0001);
        rd_chk("sts_running", `EHRS_OFS_STS, 32'h0000_0000);
        access(1'b1, `EHRS_OFS_CMD, 32'h0000_0000);
        cyc(3);
        // Pipeline not drained: halted must still read zero
        rd_chk("sts_draining", `EHRS_OFS_STS, 32'h0000_0000);
        @(posedge clock);
        pipe_idle <= 1'b1;
        cyc(2);
        rd_chk("sts_halted", `EHRS_OFS_STS, STS_IDLE);
        check("sched_run_off", {31'h0, sched_run}, 32'h0000_0000);
    endtask

    // Pending bits: set by events, kept by zero writes, cleared by one writes
    task automatic t_events();
        pulse_evt(6'h3F);
        cyc(1);
        rd_chk("sts_all_events", `EHRS_OFS_STS, 32'h0000_103F);
        // A zero write to status keeps every pending bit set
        access(1'b1, `EHRS_OFS_STS, 32'h0000_0000);
        rd_chk("sts_write_zero", `EHRS_OFS_STS, 32'h0000_103F);
        access(1'b1, `EHRS_OFS_STS, 32'h0000_003F);
        // Async advance bit is read-only and survives the clear
        rd_chk("sts_write_one", `EHRS_OFS_STS, 32'h0000_1020);
        access(1'b1, 8'h40, 32'h0000_0001);
        rd_chk("unmapped_write", `EHRS_OFS_CMD, 32'h0000_0000);
        // Byte lane zero disabled: the run write must be dropped
        access(1'b1, `EHRS_OFS_CMD, 32'h0000_0001, 4'h0);
        rd_chk("be_off_write", `EHRS_OFS_CMD, 32'h0000_0000);
    endtask

    // Host bus error while running stops the schedule
    task automatic t_host_error();
        access(1'b1, `EHRS_OFS_CMD, 32'h0000_0001);
        pulse_evt(6'h10);
        cyc(2);
        rd_chk("cmd_after_hse", `EHRS_OFS_CMD, 32'h0000_0000);
        rd_chk("sts_after_hse", `EHRS_OFS_STS, 32'h0000_1030);
    endtask

    // Schedule status follows the enables at a boundary, reclamation flag
    task automatic t_schedules();
        access(1'b1, `EHRS_OFS_CMD, 32'h0000_0021);
        cyc(2);
        // Running: the change waits for a schedule boundary
        check("async_lag", {31'h0, async_run}, 32'h0000_0000);
        @(posedge clock);
        sched_boundary <= 1'b1;
        @(posedge clock);
        sched_boundary <= 1'b0;
        cyc(1);
        rd_chk("sts_async_on", `EHRS_OFS_STS, 32'h0000_8030);
        @(posedge clock);
        async_empty_set <= 1'b1;
        @(posedge clock);
        async_empty_set <= 1'b0;
        rd_chk("sts_async_empty_detect_set", `EHRS_OFS_STS, 32'h0000_A030);
        @(posedge clock);
        async_empty_clr <= 1'b1;
        @(posedge clock);
        async_empty_clr <= 1'b0;
        rd_chk("sts_async_empty_detect_clr", `EHRS_OFS_STS, 32'h0000_8030);
        access(1'b1, `EHRS_OFS_CMD, 32'h0000_0010);
        cyc(3);
        rd_chk("sts_periodic_on", `EHRS_OFS_STS, 32'h0000_5030);
        check("periodic_run", {31'h0, periodic_run}, 32'h0000_0001);
    endtask

    // Soft reset from the halted state, with a zero write meanwhile
    task automatic t_soft_reset();
        int n;
        // Software confirms the controller is halted before resetting it
        rd_chk("sts_before_reset", `EHRS_OFS_STS, 32'h0000_5030);
        access(1'b1, `EHRS_OFS_CMD, 32'h0000_0032);
        check("core_reset_on", {31'h0, core_reset}, 32'h0000_0001);
        check("txn_abort_on", {31'h0, txn_abort}, 32'h0000_0001);
        check("bus_reset_block", {31'h0, bus_reset_block}, 32'h0000_0001);
        check("port_release", {31'h0, port_own_release}, 32'h0000_0001);
        rd_chk("cmd_in_reset", `EHRS_OFS_CMD, 32'h0000_0002);
        access(1'b1, `EHRS_OFS_CMD, 32'h0000_0000);
        rd_chk("cmd_zero_ignored", `EHRS_OFS_CMD, 32'h0000_0002);
        n = 0;
        while (core_reset !== 1'b0 && n < 20) begin
            cyc(1);
            n++;
        end
        check("reset_ends", {31'h0, core_reset}, 32'h0000_0000);
        check("abort_ends", {31'h0, txn_abort}, 32'h0000_0000);
        check("ports_back", {31'h0, port_own_release}, 32'h0000_0000);
        cyc(2);
        rd_chk("cmd_after_reset", `EHRS_OFS_CMD, 32'h0000_0000);
        rd_chk("sts_after_reset", `EHRS_OFS_STS, STS_IDLE);
        check("state_after_reset", {28'h0, sched_state}, 32'h0000_0001);
        access(1'b1, `EHRS_OFS_CMD, 32'h0000_0001);
        rd_chk("cmd_usable_again", `EHRS_OFS_CMD, 32'h0000_0001);
    endtask

    // Hardware reset in mid-run: run/stop, command register and schedule state back to their initial values
    task automatic t_hw_reset();
        @(posedge clock);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        cyc(1);
        check("run_after_hw_reset", {31'h0, sched_run}, 32'h0000_0000);
        check("state_after_hw_reset", {28'h0, sched_state}, 32'h0000_0001);
        rd_chk("cmd_after_hw_reset", `EHRS_OFS_CMD, 32'h0000_0000);
    endtask

    // ==========================================
    // Main sequence
    initial begin
        sys_rst = 1'b1;
        reg_req = 1'b0;
        reg_we = 1'b0;
        reg_addr = 8'h00;
        reg_be = 4'h0;
        reg_wdata = 32'h0000_0000;
        pipe_idle = 1'b1;
        sched_boundary = 1'b0;
        async_empty_set = 1'b0;
        async_empty_clr = 1'b0;
        evt = 6'h00;
        mismatches = 0;
        num_checks = 0;
        cycles = 0;
        repeat (8) @(posedge clock);
        sys_rst <= 1'b0;
        cyc(1);
        t_reset_values();
        t_run_stop();
        t_events();
        t_host_error();
        t_schedules();
        t_soft_reset();
        t_hw_reset();
        wrap_up();
    end
endmodule
